// ### pbsa_brake_ctrl.sv
// Purpose: per-pair brake source selection and level brake actions
// Assumes: all inputs synchronous to clk, unlock driven by system block
// Notes: outputs per channel are registered and lag a source level by one cycle, a software trigger by two
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pbsa_brake_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [pbsa_pkg::PBSA_AW-1:0] reg_addr,
	input wire logic [pbsa_pkg::PBSA_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pbsa_pkg::PBSA_DW-1:0] reg_rdata,
	// protection
	input wire logic global_write_unlock,
	// brake sources
	input wire logic brake_input_zero,
	input wire logic brake_input_one,
	input wire logic lockup_detect,
	input wire logic brownout_detect,
	input wire logic clock_fail_detect,
	// brake state
	output logic [pbsa_pkg::PBSA_NPAIR-1:0] level_brake_flag,
	output logic [pbsa_pkg::PBSA_NPAIR-1:0] edge_brake_flag,
	// channel overrides
	output logic [pbsa_pkg::PBSA_NCH-1:0] ch_brake_tristate,
	output logic [pbsa_pkg::PBSA_NCH-1:0] ch_brake_force,
	output logic [pbsa_pkg::PBSA_NCH-1:0] ch_brake_level
);
	import pbsa_pkg::*;

	logic [PBSA_NPAIR-1:0][31:0] ctrl_q, ctrl_d;
	logic [31:0] fail_q, fail_d;
	logic [31:0] rdata_q, rdata_d;
	logic pin0_q, pin0_d, pin1_q, pin1_d, sys_q, sys_d;
	logic sysfail;
	logic pin0_rise, pin1_rise, sys_rise;
	logic ctrl_wr_ok, sw_wr_ok, status_wr;
	logic [PBSA_NPAIR-1:0] sw_lvl_trig, sw_edge_trig;
	logic [PBSA_NPAIR-1:0] lvl_clr, edge_clr, lvl_src;
	logic [PBSA_NPAIR-1:0][2:0] even_act, odd_act;

	always_comb begin
		sysfail = (lockup_detect & fail_q[PBSA_LOCKUP_EN_BIT]) |
			(brownout_detect & fail_q[PBSA_BROWNOUT_EN_BIT]) |
			(clock_fail_detect & fail_q[PBSA_CLKMON_EN_BIT]);
	end

	// edge history shared by all pairs
	always_comb begin
		pin0_d = brake_input_zero;
		pin1_d = brake_input_one;
		sys_d = sysfail;
		pin0_rise = brake_input_zero & ~pin0_q;
		pin1_rise = brake_input_one & ~pin1_q;
		sys_rise = sysfail & ~sys_q;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin0_q <= 1'b0;
			pin1_q <= 1'b0;
			sys_q <= 1'b0;
		end else begin
			pin0_q <= pin0_d;
			pin1_q <= pin1_d;
			sys_q <= sys_d;
		end
	end

	always_comb begin
		ctrl_wr_ok = reg_wr & pbsa_ctrl_hit(reg_addr) & global_write_unlock;
		sw_wr_ok = reg_wr & (reg_addr == PBSA_OFF_SW_BRK) &
			global_write_unlock;
		status_wr = reg_wr & (reg_addr == PBSA_OFF_BRK_STATUS);
	end

	always_comb begin
		sw_lvl_trig = sw_wr_ok ?
			reg_wdata[PBSA_LVL_TRIG_LSB +: PBSA_NPAIR] : '0;
		sw_edge_trig = sw_wr_ok ?
			reg_wdata[PBSA_EDGE_TRIG_LSB +: PBSA_NPAIR] : '0;
		lvl_clr = status_wr ?
			reg_wdata[PBSA_LVL_TRIG_LSB +: PBSA_NPAIR] : '0;
		edge_clr = status_wr ?
			reg_wdata[PBSA_EDGE_TRIG_LSB +: PBSA_NPAIR] : '0;
	end

	// register writes and read answer
	always_comb begin
		ctrl_d = ctrl_q;
		fail_d = fail_q;
		rdata_d = '0;
		if (ctrl_wr_ok) begin
			ctrl_d[pbsa_ctrl_slot(reg_addr)] = reg_wdata & PBSA_BRK_CTRL_MASK;
		end
		if (reg_wr && reg_addr == PBSA_OFF_FAIL_BRK) begin
			fail_d = reg_wdata & PBSA_FAIL_BRK_MASK;
		end
		// unmapped and write-only offsets read as zero
		if (reg_rd) begin
			if (pbsa_ctrl_hit(reg_addr)) begin
				rdata_d = ctrl_q[pbsa_ctrl_slot(reg_addr)];
			end else if (reg_addr == PBSA_OFF_FAIL_BRK) begin
				rdata_d = fail_q;
			end else if (reg_addr == PBSA_OFF_BRK_STATUS) begin
				rdata_d[PBSA_LVL_TRIG_LSB +: PBSA_NPAIR] = level_brake_flag;
				rdata_d[PBSA_EDGE_TRIG_LSB +: PBSA_NPAIR] = edge_brake_flag;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= {PBSA_NPAIR{PBSA_RST_BRK_CTRL}};
			fail_q <= PBSA_RST_FAIL_BRK;
			rdata_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			fail_q <= fail_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// one detector per pair
	genvar g;
	generate
		for (g = 0; g < PBSA_NPAIR; g++) begin : g_pair
			pbsa_pair u_pair (
				.clk(clk),
				.rstn(rstn),
				.ctrl(ctrl_q[g]),
				.pin0_lvl(brake_input_zero),
				.pin1_lvl(brake_input_one),
				.sys_lvl(sysfail),
				.pin0_rise(pin0_rise),
				.pin1_rise(pin1_rise),
				.sys_rise(sys_rise),
				.sw_lvl_trig(sw_lvl_trig[g]),
				.sw_edge_trig(sw_edge_trig[g]),
				.lvl_clr(lvl_clr[g]),
				.edge_clr(edge_clr[g]),
				.lvl_src(lvl_src[g]),
				.level_brake_flag(level_brake_flag[g]),
				.edge_brake_flag(edge_brake_flag[g]),
				.even_act(even_act[g]),
				.odd_act(odd_act[g])
			);
			assign ch_brake_tristate[2*g] = even_act[g][2];
			assign ch_brake_force[2*g] = even_act[g][1];
			assign ch_brake_level[2*g] = even_act[g][0];
			assign ch_brake_tristate[2*g+1] = odd_act[g][2];
			assign ch_brake_force[2*g+1] = odd_act[g][1];
			assign ch_brake_level[2*g+1] = odd_act[g][0];
		end
	endgenerate

	// checks on pair 0 (a few on pairs 1 and 2), the pairs share the same module
	logic [31:0] c0;
	assign c0 = ctrl_q[0];

	AST_ODD_ACTION: assert property (
		@(posedge clk) disable iff (!rstn)
		(lvl_src[0] && c0[PBSA_ODD_ACT_LSB +: 2] == PBSA_ACT_HIGH)
		|=> (ch_brake_force[1] && ch_brake_level[1] && !ch_brake_tristate[1]))
		else $error("odd channel not forced high on level brake");

	AST_EVEN_ACTION: assert property (
		@(posedge clk) disable iff (!rstn)
		(lvl_src[0] && c0[PBSA_EVEN_ACT_LSB +: 2] == PBSA_ACT_TRISTATE)
		|=> (ch_brake_tristate[0] && !ch_brake_force[0]))
		else $error("even channel not tri-stated on level brake");

	AST_NO_ACTION: assert property (
		@(posedge clk) disable iff (!rstn)
		(c0[PBSA_ODD_ACT_LSB +: 2] == PBSA_ACT_NONE &&
		c0[PBSA_EVEN_ACT_LSB +: 2] == PBSA_ACT_NONE)
		|=> (ch_brake_force[1:0] == 2'h0 && ch_brake_tristate[1:0] == 2'h0) ||
		$changed(c0))
		else $error("channel overridden with no action selected");

	AST_SYS_LEVEL: assert property (
		@(posedge clk) disable iff (!rstn)
		(sysfail && c0[PBSA_SYS_LVL_BIT]) |=> level_brake_flag[0])
		else $error("system fail did not raise level brake");

	AST_SYS_LEVEL_OFF: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(level_brake_flag[0]) |->
		$past(lvl_src[0] || sw_lvl_trig[0]))
		else $error("level brake raised by a disabled source");

	AST_PIN1_LEVEL: assert property (
		@(posedge clk) disable iff (!rstn)
		(brake_input_one && c0[PBSA_PIN1_LVL_BIT]) |=> level_brake_flag[0])
		else $error("pin one did not raise level brake");

	AST_PIN0_LEVEL: assert property (
		@(posedge clk) disable iff (!rstn)
		(brake_input_zero && c0[PBSA_PIN0_LVL_BIT]) |=> level_brake_flag[0])
		else $error("pin zero did not raise level brake");

	AST_PIN0_EDGE: assert property (
		@(posedge clk) disable iff (!rstn)
		($rose(brake_input_zero) && c0[PBSA_PIN0_EDGE_BIT])
		|=> edge_brake_flag[0])
		else $error("pin zero edge did not raise edge brake");

	AST_PIN1_EDGE: assert property (
		@(posedge clk) disable iff (!rstn)
		($rose(brake_input_one) && c0[PBSA_PIN1_EDGE_BIT])
		|=> edge_brake_flag[0])
		else $error("pin one edge did not raise edge brake");

	AST_SYS_EDGE: assert property (
		@(posedge clk) disable iff (!rstn)
		($rose(sysfail) && c0[PBSA_SYS_EDGE_BIT]) |=> edge_brake_flag[0])
		else $error("system fail edge did not raise edge brake");

	AST_EDGE_CAUSE: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(edge_brake_flag[0]) |->
		$past((pin0_rise && c0[PBSA_PIN0_EDGE_BIT]) ||
		(pin1_rise && c0[PBSA_PIN1_EDGE_BIT]) ||
		(sys_rise && c0[PBSA_SYS_EDGE_BIT]) || sw_edge_trig[0]))
		else $error("edge brake raised without an enabled cause");

	AST_LOCKED_HOLD: assert property (
		@(posedge clk) disable iff (!rstn)
		(!global_write_unlock && !ctrl_wr_ok) |=> $stable(ctrl_q))
		else $error("control word changed while locked");

	AST_UNLOCKED_WRITE: assert property (
		@(posedge clk) disable iff (!rstn)
		(reg_wr && global_write_unlock && reg_addr == PBSA_OFF_BRK_CTRL1)
		|=> ctrl_q[1] == ($past(reg_wdata) & PBSA_BRK_CTRL_MASK))
		else $error("unlocked control write not stored");

	AST_RESET_ZERO: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> (ctrl_q == '0 && ch_brake_force == '0))
		else $error("control words not zero after reset");

	AST_READBACK: assert property (
		@(posedge clk) disable iff (!rstn)
		(reg_rd && reg_addr == PBSA_OFF_BRK_CTRL2)
		|=> reg_rdata == $past(ctrl_q[2]) ##1 reg_rdata == '0 || $past(reg_rd))
		else $error("control word readback wrong");

	AST_FAIL_GATE: assert property (
		@(posedge clk) disable iff (!rstn)
		(c0[PBSA_SYS_LVL_BIT] &&
		((lockup_detect && fail_q[PBSA_LOCKUP_EN_BIT]) ||
		(brownout_detect && fail_q[PBSA_BROWNOUT_EN_BIT]) ||
		(clock_fail_detect && fail_q[PBSA_CLKMON_EN_BIT])))
		|=> level_brake_flag[0])
		else $error("enabled fail detector did not raise level brake");

	AST_FAIL_OFF: assert property (
		@(posedge clk) disable iff (!rstn)
		(fail_q == '0 && !sw_edge_trig[0] && !edge_brake_flag[0] &&
		!c0[PBSA_PIN0_EDGE_BIT] && !c0[PBSA_PIN1_EDGE_BIT])
		|=> !edge_brake_flag[0])
		else $error("edge brake raised with every fail detector off");

	AST_SW_LEVEL: assert property (
		@(posedge clk) disable iff (!rstn)
		(reg_wr && global_write_unlock && reg_addr == PBSA_OFF_SW_BRK &&
		reg_wdata[PBSA_LVL_TRIG_LSB])
		|=> level_brake_flag[0] && !$past(reg_rd))
		else $error("software level trigger did not set flag");

	AST_FLAG_HOLD: assert property (
		@(posedge clk) disable iff (!rstn)
		(level_brake_flag[0] && !lvl_clr[0]) |=> level_brake_flag[0])
		else $error("level flag dropped without a clear");

	AST_PAIR1_QUIET: assert property (
		@(posedge clk) disable iff (!rstn)
		(ctrl_q[1] == '0 && !sw_lvl_trig[1] && !level_brake_flag[1])
		|=> !level_brake_flag[1])
		else $error("pair one level brake raised with a zero control word");

	AST_FLAG_ACTION: assert property (
		@(posedge clk) disable iff (!rstn)
		(level_brake_flag[0] && c0[PBSA_ODD_ACT_LSB +: 2] == PBSA_ACT_LOW)
		|=> (ch_brake_force[1] && !ch_brake_level[1]))
		else $error("held level brake did not force odd channel low");

	AST_SW_LOCKED: assert property (
		@(posedge clk) disable iff (!rstn)
		(reg_wr && !global_write_unlock && reg_addr == PBSA_OFF_SW_BRK &&
		!lvl_src[0] && !level_brake_flag[0]) |=> !level_brake_flag[0])
		else $error("locked software trigger raised a level brake");

	AST_RDATA_IDLE: assert property (
		@(posedge clk) disable iff (!rstn)
		!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside a read");

	COV_LEVEL_FORCE_LOW: cover property (
		@(posedge clk) disable iff (!rstn)
		lvl_src[0] && c0[PBSA_ODD_ACT_LSB +: 2] == PBSA_ACT_LOW
		##1 ch_brake_force[1]);

	COV_SW_EDGE: cover property (
		@(posedge clk) disable iff (!rstn)
		sw_edge_trig[2] ##1 edge_brake_flag[2]);

	COV_LOCKED_WRITE: cover property (
		@(posedge clk) disable iff (!rstn)
		reg_wr && pbsa_ctrl_hit(reg_addr) && !global_write_unlock);

	COV_SET_CLEAR: cover property (
		@(posedge clk) disable iff (!rstn)
		lvl_clr[0] && lvl_src[0] ##1 level_brake_flag[0]);

endmodule // pbsa_brake_ctrl

`default_nettype wire

// ### pbsa_pkg.sv
// Purpose: shared constants and decode helpers for the pwm brake control
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: one control word per channel pair, pairs 0/1, 2/3, 4/5
`default_nettype none

package pbsa_pkg;

	localparam int PBSA_NPAIR = 3;
	localparam int PBSA_NCH = 6;
	localparam int PBSA_AW = 8;
	localparam int PBSA_DW = 32;

	// register byte offsets
	localparam logic [7:0] PBSA_OFF_FAIL_BRK = 8'hc4;
	localparam logic [7:0] PBSA_OFF_BRK_CTRL0 = 8'hc8;
	localparam logic [7:0] PBSA_OFF_BRK_CTRL1 = 8'hcc;
	localparam logic [7:0] PBSA_OFF_BRK_CTRL2 = 8'hd0;
	localparam logic [7:0] PBSA_OFF_SW_BRK = 8'hdc;
	localparam logic [7:0] PBSA_OFF_BRK_STATUS = 8'hf0;

	// reset values
	localparam logic [31:0] PBSA_RST_BRK_CTRL = 32'h0000_0000;
	localparam logic [31:0] PBSA_RST_FAIL_BRK = 32'h0000_0000;

	// brake control field positions
	localparam int PBSA_ODD_ACT_LSB = 18;
	localparam int PBSA_EVEN_ACT_LSB = 16;
	localparam int PBSA_SYS_LVL_BIT = 15;
	localparam int PBSA_PIN1_LVL_BIT = 13;
	localparam int PBSA_PIN0_LVL_BIT = 12;
	localparam int PBSA_SYS_EDGE_BIT = 7;
	localparam int PBSA_PIN1_EDGE_BIT = 5;
	localparam int PBSA_PIN0_EDGE_BIT = 4;
	localparam logic [31:0] PBSA_BRK_CTRL_MASK = 32'h000f_b0b0;

	// fail brake field positions
	localparam int PBSA_LOCKUP_EN_BIT = 3;
	localparam int PBSA_BROWNOUT_EN_BIT = 1;
	localparam int PBSA_CLKMON_EN_BIT = 0;
	localparam logic [31:0] PBSA_FAIL_BRK_MASK = 32'h0000_000b;

	// software trigger and status field positions
	localparam int PBSA_LVL_TRIG_LSB = 8;
	localparam int PBSA_EDGE_TRIG_LSB = 0;

	// action codes
	localparam logic [1:0] PBSA_ACT_NONE = 2'h0;
	localparam logic [1:0] PBSA_ACT_TRISTATE = 2'h1;
	localparam logic [1:0] PBSA_ACT_LOW = 2'h2;
	localparam logic [1:0] PBSA_ACT_HIGH = 2'h3;

	// returns {tristate, force, level}
	function automatic logic [2:0] pbsa_decode_action(input logic [1:0] act);
		unique case (act)
			PBSA_ACT_NONE: return 3'h0;
			PBSA_ACT_TRISTATE: return 3'h4;
			PBSA_ACT_LOW: return 3'h2;
			PBSA_ACT_HIGH: return 3'h3;
		endcase
	endfunction

	function automatic logic pbsa_ctrl_hit(input logic [7:0] a);
		return (a == PBSA_OFF_BRK_CTRL0) || (a == PBSA_OFF_BRK_CTRL1) ||
			(a == PBSA_OFF_BRK_CTRL2);
	endfunction

	function automatic logic [1:0] pbsa_ctrl_slot(input logic [7:0] a);
		logic [7:0] d;
		d = a - PBSA_OFF_BRK_CTRL0;
		return d[3:2];
	endfunction

endpackage

`default_nettype wire

// ### pbsa_pair.sv
// Purpose: brake detection and output action for one channel pair
// Assumes: source inputs already synchronous and filtered
// Notes: level brake holds while its flag is set
`timescale 1ns/1ps
`default_nettype none

module pbsa_pair (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// configuration
	input wire logic [31:0] ctrl,
	// sources
	input wire logic pin0_lvl,
	input wire logic pin1_lvl,
	input wire logic sys_lvl,
	input wire logic pin0_rise,
	input wire logic pin1_rise,
	input wire logic sys_rise,
	// software
	input wire logic sw_lvl_trig,
	input wire logic sw_edge_trig,
	input wire logic lvl_clr,
	input wire logic edge_clr,
	// results
	output logic lvl_src,
	output logic level_brake_flag,
	output logic edge_brake_flag,
	output logic [2:0] even_act,
	output logic [2:0] odd_act
);
	import pbsa_pkg::*;

	logic lvl_flag_q, lvl_flag_d, edge_flag_q, edge_flag_d;
	logic [2:0] even_q, even_d, odd_q, odd_d;
	logic edge_src, lvl_active;

	always_comb begin
		lvl_src = (pin0_lvl & ctrl[PBSA_PIN0_LVL_BIT]) |
			(pin1_lvl & ctrl[PBSA_PIN1_LVL_BIT]) |
			(sys_lvl & ctrl[PBSA_SYS_LVL_BIT]);
		edge_src = (pin0_rise & ctrl[PBSA_PIN0_EDGE_BIT]) |
			(pin1_rise & ctrl[PBSA_PIN1_EDGE_BIT]) |
			(sys_rise & ctrl[PBSA_SYS_EDGE_BIT]);
		// set wins over a clear in the same cycle
		lvl_flag_d = (lvl_flag_q & ~lvl_clr) | lvl_src | sw_lvl_trig;
		edge_flag_d = (edge_flag_q & ~edge_clr) | edge_src | sw_edge_trig;
		lvl_active = lvl_src | lvl_flag_q;
		even_d = lvl_active ?
			pbsa_decode_action(ctrl[PBSA_EVEN_ACT_LSB +: 2]) : 3'h0;
		odd_d = lvl_active ?
			pbsa_decode_action(ctrl[PBSA_ODD_ACT_LSB +: 2]) : 3'h0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl_flag_q <= 1'b0;
			edge_flag_q <= 1'b0;
			even_q <= 3'h0;
			odd_q <= 3'h0;
		end else begin
			lvl_flag_q <= lvl_flag_d;
			edge_flag_q <= edge_flag_d;
			even_q <= even_d;
			odd_q <= odd_d;
		end
	end

	assign level_brake_flag = lvl_flag_q;
	assign edge_brake_flag = edge_flag_q;
	assign even_act = even_q;
	assign odd_act = odd_q;

endmodule // pbsa_pair

`default_nettype wire

// ### pbsa_src_model.sv
// Purpose: model of the brake pins and the system fail detectors
// Assumes: bench asks for source levels on req, one bit per source
// Notes: slow adds one cycle of delay; released sources fall to 0
`timescale 1ns/1ps
`default_nettype none

module pbsa_src_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bench control
	input wire logic [4:0] req,
	input wire logic slow,
	// {clock fail, brownout, lockup, pin one, pin zero}
	output logic [4:0] src
);
	logic [4:0] stage_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage_q <= 5'h0;
			src <= 5'h0;
		end else begin
			stage_q <= req;
			src <= slow ? stage_q : req;
		end
	end
endmodule // pbsa_src_model

`default_nettype wire

// ### pwm_brake_source_action_ctrl_tb_top.sv
// Purpose: self-checking bench for the pwm brake control block
// Assumes: sources come from the partner model, registers via plain port
// Notes: random values from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none

module pwm_brake_source_action_ctrl_tb_top;
	import pbsa_pkg::*;
	logic clk, rstn, reg_wr, reg_rd, unlock, slow, le, ee, fe;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rnd;
	logic [31:0] keep [3];
	logic [4:0] req, src;
	logic [3:0] cc;
	logic [2:0] lvl_f, edge_f;
	logic [5:0] tri_o, frc_o, lev_o;
	int failures, total_checks, pi, si, ki;
	int lbit [3] = '{12, 13, 15};
	int ebit [3] = '{4, 5, 7};
	int fbit [3] = '{3, 1, 0};

	always #12.5 clk = ~clk;

	pbsa_src_model u_pbsa_src_model (
		.clk(clk), .rstn(rstn), .req(req), .slow(slow), .src(src));

	pbsa_brake_ctrl u_pbsa_brake_ctrl (
		.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .global_write_unlock(unlock),
		.brake_input_zero(src[0]), .brake_input_one(src[1]),
		.lockup_detect(src[2]), .brownout_detect(src[3]),
		.clock_fail_detect(src[4]), .level_brake_flag(lvl_f),
		.edge_brake_flag(edge_f), .ch_brake_tristate(tri_o),
		.ch_brake_force(frc_o), .ch_brake_level(lev_o));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// expected {tristate, force, level} for one action code
	function automatic logic [2:0] act3(input logic [1:0] a);
		return {a == 2'h1, a[1], a == 2'h3};
	endfunction

	function automatic logic [7:0] coff(input int p);
		return PBSA_OFF_BRK_CTRL0 + 8'(4 * p);
	endfunction

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, e);
	endtask

	// sources off first: a live source would keep the flag set
	task automatic quiet();
		req <= 5'h0;
		cyc(4);
		unlock <= 1'b1;
		for (int p = 0; p < 3; p++)
			wr(coff(p), 32'h0);
		wr(PBSA_OFF_BRK_STATUS, 32'h0000_0707);
		cyc(2);
		#1;
		chk("flags", 32'({lvl_f, edge_f, frc_o, tri_o}), 32'h0);
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		unlock = 1'b0;
		req = 5'h0;
		slow = 1'b0;
		rnd = 32'he7f9;
		failures = 0;
		total_checks = 0;
		cyc(12);
		rstn <= 1'b1;
		for (int p = 0; p < 3; p++)
			rchk(coff(p), 32'h0);
		wr(PBSA_OFF_BRK_CTRL0, 32'hffff_ffff);
		rchk(PBSA_OFF_BRK_CTRL0, 32'h0);
		rchk(8'h40, 32'h0);
		for (int r = 0; r < 2; r++) begin
			unlock <= (r == 0);
			for (int p = 0; p < 3; p++) begin
				rnd = xs(rnd);
				if (r == 0)
					keep[p] = rnd & PBSA_BRK_CTRL_MASK;
				wr(coff(p), rnd);
			end
			for (int p = 0; p < 3; p++)
				rchk(coff(p), keep[p]);
		end
		@(posedge clk);
		#1;
		chk("rdata idle", reg_rdata, 32'h0);
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
		rchk(PBSA_OFF_BRK_CTRL2, 32'h0);
		// every odd/even action pair on every channel pair
		for (int p = 0; p < 3; p++)
			for (int c = 0; c < 16; c++) begin
				rnd = xs(rnd);
				cc = 4'(c);
				slow <= rnd[0];
				unlock <= 1'b1;
				wr(coff(p), {12'h0, cc, 16'h1000});
				req <= 5'h01;
				cyc(4);
				#1;
				chk("odd", 32'({tri_o[2*p+1], frc_o[2*p+1],
					lev_o[2*p+1]}), 32'(act3(cc[3:2])));
				chk("even", 32'({tri_o[2*p], frc_o[2*p],
					lev_o[2*p]}), 32'(act3(cc[1:0])));
				chk("level", 32'(lvl_f), 32'(3'h1 << p));
				quiet();
			end
		// source enables, level and edge, fail detectors
		for (int i = 0; i < 12; i++) begin
			rnd = xs(rnd);
			si = i % 3;
			le = ((i / 3) % 2) == 1;
			pi = int'(rnd[7:0]) % 3;
			ki = int'(rnd[15:8]) % 3;
			ee = rnd[16];
			fe = rnd[17] | (si != 2);
			slow <= rnd[18];
			unlock <= 1'b1;
			wr(PBSA_OFF_FAIL_BRK, fe ? 32'h1 << fbit[ki] : 32'h0);
			rchk(PBSA_OFF_FAIL_BRK, fe ? 32'h1 << fbit[ki] : 32'h0);
			wr(coff(pi), (32'(le) << lbit[si]) | (32'(ee) << ebit[si]));
			req <= (si == 2) ? 5'h04 << ki : 5'h01 << si;
			cyc(4);
			#1;
			chk("level", 32'(lvl_f), 32'(le & fe) << pi);
			chk("edge", 32'(edge_f), 32'(ee & fe) << pi);
			quiet();
		end
		// software trigger, refused while locked
		for (int p = 0; p < 3; p++) begin
			unlock <= 1'b1;
			wr(coff(p), 32'h000a_0000);
			unlock <= 1'b0;
			wr(PBSA_OFF_SW_BRK, 32'h101 << p);
			cyc(2);
			#1;
			chk("locked", 32'({lvl_f, edge_f}), 32'h0);
			unlock <= 1'b1;
			wr(PBSA_OFF_SW_BRK, 32'h101 << p);
			cyc(2);
			#1;
			chk("sw", 32'({lvl_f, edge_f}), 32'h9 << p);
			chk("force", 32'(frc_o | lev_o), 32'h3 << (2 * p));
			rchk(PBSA_OFF_BRK_STATUS, 32'h101 << p);
			rchk(PBSA_OFF_SW_BRK, 32'h0);
			quiet();
		end
		complete_run();
	end
endmodule // pwm_brake_source_action_ctrl_tb_top

`default_nettype wire
